// ==== async_adapter_core.sv ====
// Purpose: Asynchronous serial adapter between an 8-bit host bus and a serial line.
// Assumes: All pins, including the bit clocks and the bus strobe, are synchronous to clk.
// Notes:   Bus effects take place on the trailing edge of the enable strobe.
`timescale 1ns/1ns
module async_adapter_core
    import async_adapter_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       enable,
    input  wire logic       chipSelect,
    input  wire logic       registerSelect,
    input  wire logic       readNotWrite,
    input  wire logic [7:0] dataIn,
    output logic [7:0]      dataOut,
    output logic            dataOe,
    input  wire logic       txClk,
    input  wire logic       rxClk,
    input  wire logic       rxData,
    output logic            txData,
    output logic            requestToSendN,
    input  wire logic       clearToSendN,
    input  wire logic       carrierDetectN,
    output logic            irqN
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobe capture

    logic       enablePrev_reg;
    logic       latchSel_reg;
    logic       latchRs_reg;
    logic       latchRw_reg;
    logic [7:0] latchData_reg;
    logic       busEnd;
    logic       wrCtrl;
    logic       wrData;
    logic       rdStatus;
    logic       rdData;

    // Address and data are captured while the strobe is high, since they may
    // already be moving in the cycle where the trailing edge is seen.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enablePrev_reg <= 1'b0;
            latchSel_reg   <= 1'b0;
            latchRs_reg    <= 1'b0;
            latchRw_reg    <= 1'b1;
            latchData_reg  <= 8'h00;
        end else begin
            enablePrev_reg <= enable;
            if (enable) begin
                latchSel_reg  <= chipSelect;
                latchRs_reg   <= registerSelect;
                latchRw_reg   <= readNotWrite;
                latchData_reg <= dataIn;
            end
        end
    end

    assign busEnd   = enablePrev_reg && !enable && latchSel_reg;
    assign wrCtrl   = busEnd && !latchRw_reg && (latchRs_reg == SEL_CTRL_STATUS);
    assign wrData   = busEnd && !latchRw_reg && (latchRs_reg == SEL_DATA);
    assign rdStatus = busEnd && latchRw_reg && (latchRs_reg == SEL_CTRL_STATUS);
    assign rdData   = busEnd && latchRw_reg && (latchRs_reg == SEL_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Control register and reset latch

    logic [7:0] ctrl_reg;
    logic       resetLatch_reg;
    logic       inReset;
    logic [1:0] divSel;
    logic [1:0] txCtrl;
    word_fmt_t  fmt;
    logic       rxIrqEn;
    logic       txIrqEn;
    logic       rxInit;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_reg <= latchData_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resetLatch_reg <= 1'b1;
        end else if (wrCtrl && (latchData_reg[1:0] == DIV_RESET)) begin
            resetLatch_reg <= 1'b0;
        end
    end

    assign divSel  = ctrl_reg[1:0];
    assign txCtrl  = ctrl_reg[6:5];
    assign fmt     = decode_word(ctrl_reg[4:2]);
    assign inReset = resetLatch_reg || (divSel == DIV_RESET);
    assign rxIrqEn = ctrl_reg[CTRL_RX_IRQ];
    assign txIrqEn = (txCtrl == TXC_IRQ_ON);
    assign rxInit  = inReset || carrierDetectN;

    ////////////////////////////////////////////////////////////////////////////
    // Bit clock dividers

    logic       txClkPrev_reg;
    logic       rxClkPrev_reg;
    logic [5:0] txDiv_reg;
    logic [5:0] fullLast;
    logic [5:0] halfLast;
    logic       txEdge;
    logic       rxEdge;
    logic       txBitTick;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txClkPrev_reg <= 1'b1;
            rxClkPrev_reg <= 1'b1;
        end else begin
            txClkPrev_reg <= txClk;
            rxClkPrev_reg <= rxClk;
        end
    end

    assign txEdge   = txClk && !txClkPrev_reg;
    assign rxEdge   = rxClk && !rxClkPrev_reg;
    assign fullLast = (divSel == DIV_BY_64) ? DIV64_LAST : DIV16_LAST;
    assign halfLast = (divSel == DIV_BY_64) ? HALF64_LAST : HALF16_LAST;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txDiv_reg <= 6'h00;
        end else if (inReset) begin
            txDiv_reg <= 6'h00;
        end else if (txEdge) begin
            txDiv_reg <= (txDiv_reg >= fullLast) ? 6'h00 : txDiv_reg + 6'h01;
        end
    end

    assign txBitTick = txEdge && ((divSel == DIV_BY_1) || (txDiv_reg >= fullLast));

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path

    logic [7:0] txHold_reg;
    logic       txEmpty_reg;
    logic       txTake;
    logic       txLine;
    logic       txEmptyShown;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txHold_reg <= 8'h00;
        end else if (wrData) begin
            txHold_reg <= latchData_reg;
        end
    end

    // A write in the same cycle as a transfer refills the now-empty holding
    // register, so the write decides the flag.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txEmpty_reg <= 1'b1;
        end else if (inReset) begin
            txEmpty_reg <= 1'b1;
        end else if (wrData) begin
            txEmpty_reg <= 1'b0;
        end else if (txTake) begin
            txEmpty_reg <= 1'b1;
        end
    end

    assign txEmptyShown = txEmpty_reg && !clearToSendN;

    async_tx_shifter txShifter (
        .clk      (clk),
        .rstn     (rstn),
        .init     (inReset),
        .bitTick  (txBitTick),
        .holdFull (!txEmpty_reg),
        .holdData (txHold_reg),
        .fmt      (fmt),
        .txd      (txLine),
        .take     (txTake)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txData         <= 1'b1;
            requestToSendN <= 1'b0;
        end else begin
            txData         <= (txCtrl == TXC_BREAK) ? 1'b0 : txLine;
            requestToSendN <= (txCtrl == TXC_RTS_HIGH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive bit timing

    logic       rxLinePrev_reg;
    logic       rxHalf_reg;
    logic       rxSync_reg;
    logic [5:0] rxCnt_reg;
    logic       halfDone;
    logic       fullDone;
    logic       rxSample;
    logic       rxDone;
    logic [7:0] rxWord;
    logic       rxParityErr;
    logic       rxFrameErr;

    assign halfDone = rxHalf_reg && (rxCnt_reg == halfLast);
    assign fullDone = rxSync_reg && (rxCnt_reg == fullLast);
    // The sample on a confirmed half bit is the start bit itself; a line that
    // went high again is dropped as a glitch.
    assign rxSample = (divSel == DIV_BY_1) ? rxEdge
                    : rxEdge && ((halfDone && !rxData) || fullDone);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxLinePrev_reg <= 1'b1;
            rxHalf_reg     <= 1'b0;
            rxSync_reg     <= 1'b0;
            rxCnt_reg      <= 6'h00;
        end else if (rxInit || (divSel == DIV_BY_1) || rxDone) begin
            rxLinePrev_reg <= 1'b1;
            rxHalf_reg     <= 1'b0;
            rxSync_reg     <= 1'b0;
            rxCnt_reg      <= 6'h00;
        end else if (rxEdge) begin
            rxLinePrev_reg <= rxData;
            if (rxHalf_reg) begin
                rxCnt_reg <= halfDone ? 6'h00 : rxCnt_reg + 6'h01;
                if (halfDone) begin
                    rxHalf_reg <= 1'b0;
                    rxSync_reg <= !rxData;
                end
            end else if (rxSync_reg) begin
                rxCnt_reg <= fullDone ? 6'h00 : rxCnt_reg + 6'h01;
            end else if (rxLinePrev_reg && !rxData) begin
                rxHalf_reg <= 1'b1;
                rxCnt_reg  <= 6'h00;
            end
        end
    end

    async_rx_shifter rxShifter (
        .clk        (clk),
        .rstn       (rstn),
        .init       (rxInit),
        .sampleTick (rxSample),
        .rxd        (rxData),
        .fmt        (fmt),
        .done       (rxDone),
        .data       (rxWord),
        .parityErr  (rxParityErr),
        .frameErr   (rxFrameErr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive holding register and status flags

    logic [7:0] rxHold_reg;
    logic       rxFull_reg;
    logic       frameErr_reg;
    logic       parityErr_reg;
    logic       overrun_reg;
    logic       overrunPend_reg;
    logic       rxLoad;

    // A read that empties the holding register lets a character finishing in
    // the same cycle in, so no character is lost to the clear.
    assign rxLoad = rxDone && (!rxFull_reg || (rdData && !overrunPend_reg));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxHold_reg    <= 8'h00;
            frameErr_reg  <= 1'b0;
            parityErr_reg <= 1'b0;
        end else if (inReset) begin
            frameErr_reg  <= 1'b0;
            parityErr_reg <= 1'b0;
        end else if (rxLoad) begin
            rxHold_reg    <= rxWord;
            frameErr_reg  <= rxFrameErr;
            parityErr_reg <= rxParityErr && fmt.parityOn;
        end
    end

    // Overrun stays hidden until the character held before it has been read.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxFull_reg      <= 1'b0;
            overrun_reg     <= 1'b0;
            overrunPend_reg <= 1'b0;
        end else if (rxInit) begin
            rxFull_reg      <= 1'b0;
            overrun_reg     <= 1'b0;
            overrunPend_reg <= 1'b0;
        end else begin
            if (rxLoad) begin
                rxFull_reg <= 1'b1;
            end else if (rdData && !overrunPend_reg) begin
                rxFull_reg <= 1'b0;
            end
            if (rdData && overrunPend_reg) begin
                overrun_reg <= 1'b1;
            end else if (rdData) begin
                overrun_reg <= 1'b0;
            end
            if (rxDone && !rxLoad) begin
                overrunPend_reg <= 1'b1;
            end else if (rdData) begin
                overrunPend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier loss, interrupt and read data

    logic    dcdPrev_reg;
    logic    dcdLoss_reg;
    logic    dcdStatusSeen_reg;
    logic    irqActive;
    status_t status;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dcdPrev_reg       <= 1'b0;
            dcdLoss_reg       <= 1'b0;
            dcdStatusSeen_reg <= 1'b0;
        end else begin
            dcdPrev_reg <= carrierDetectN;
            if (carrierDetectN && !dcdPrev_reg) begin
                dcdLoss_reg       <= 1'b1;
                dcdStatusSeen_reg <= 1'b0;
            end else if (inReset || (rdData && dcdStatusSeen_reg)) begin
                dcdLoss_reg       <= carrierDetectN;
                dcdStatusSeen_reg <= 1'b0;
            end else if (rdStatus && dcdLoss_reg) begin
                dcdStatusSeen_reg <= 1'b1;
            end
        end
    end

    assign irqActive = (rxIrqEn && (rxFull_reg || dcdLoss_reg))
                     || (txIrqEn && txEmptyShown);

    always_comb begin
        status           = '0;
        status.irq       = irqActive;
        status.parityErr = parityErr_reg;
        status.overrun   = overrun_reg;
        status.frameErr  = frameErr_reg;
        status.cts       = clearToSendN;
        status.dcdLoss   = dcdLoss_reg;
        status.txEmpty   = txEmptyShown;
        status.rxFull    = rxFull_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dataOut <= 8'h00;
            dataOe  <= 1'b0;
            irqN    <= 1'b1;
        end else begin
            dataOut <= (registerSelect == SEL_DATA) ? rxHold_reg : status;
            dataOe  <= enable && chipSelect && readNotWrite;
            irqN    <= !irqActive;
        end
    end

endmodule

// ==== async_adapter_pkg.sv ====
// Purpose: Shared constants and types for the asynchronous serial adapter.
// Assumes: 8-bit host bus, one system clock.
// Notes:   Functional notes follow.
// Functional notes
// - Format changes act at once, no buffering.
// - RTS pin high only for code 10.
// - Transmit interrupt enabled only for code 01.
// - Code 11 sends break, RTS low.
// - Bit 7 enables receive-full and carrier interrupts.
// - Data write loads holding, clears empty flag.
// - Idle transmitter starts within one bit time.
// - Queued character follows; empty set on transfer.
// - Complete character moves to empty holding register.
// - Data read clears full flag, keeps data.
// - Full holding register blocks new transfer.
// - Two locations, four registers, fixed directions.
// - Power-on latch released only by code 11.
// - One start bit, one or two stops.
// - Parity bit sits between data and stop.
// - Divide-by-1 unsynchronized; 16, 64 self-synchronize.
// - Receiver aligns to start bit falling edge.
// - Start must hold half bit to count.
// - Receiver reports parity, framing, overrun, full.
// - Receiver is double buffered.
// - Bits 1:0 pick divide ratio or reset.
// - Bits 4:2 pick word, parity, stops.
// - Carrier detect high holds receiver initialized.
// - CTS high hides empty flag, reads high.
package async_adapter_pkg;

    localparam logic       SEL_CTRL_STATUS = 1'b0;
    localparam logic       SEL_DATA        = 1'b1;
    localparam int         CTRL_RX_IRQ     = 7;
    localparam logic [1:0] DIV_BY_1        = 2'h0;
    localparam logic [1:0] DIV_BY_16       = 2'h1;
    localparam logic [1:0] DIV_BY_64       = 2'h2;
    localparam logic [1:0] DIV_RESET       = 2'h3;
    localparam logic [1:0] TXC_IRQ_ON      = 2'h1;
    localparam logic [1:0] TXC_RTS_HIGH    = 2'h2;
    localparam logic [1:0] TXC_BREAK       = 2'h3;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [5:0] DIV16_LAST      = 6'h0F;
    localparam logic [5:0] DIV64_LAST      = 6'h3F;
    localparam logic [5:0] HALF16_LAST     = 6'h07;
    localparam logic [5:0] HALF64_LAST     = 6'h1F;
    localparam logic [2:0] LAST_BIT_7      = 3'h6;
    localparam logic [2:0] LAST_BIT_8      = 3'h7;

    typedef struct packed {
        logic eightBits;
        logic parityOn;
        logic parityOdd;
        logic twoStop;
    } word_fmt_t;

    // Packed most significant first, so the layout matches the read value.
    typedef struct packed {
        logic irq;
        logic parityErr;
        logic overrun;
        logic frameErr;
        logic cts;
        logic dcdLoss;
        logic txEmpty;
        logic rxFull;
    } status_t;

    function automatic word_fmt_t decode_word(input logic [2:0] sel);
        word_fmt_t f;
        case (sel)
            3'h0:    f = '{1'b0, 1'b1, 1'b0, 1'b1};
            3'h1:    f = '{1'b0, 1'b1, 1'b1, 1'b1};
            3'h2:    f = '{1'b0, 1'b1, 1'b0, 1'b0};
            3'h3:    f = '{1'b0, 1'b1, 1'b1, 1'b0};
            3'h4:    f = '{1'b1, 1'b0, 1'b0, 1'b1};
            3'h5:    f = '{1'b1, 1'b0, 1'b0, 1'b0};
            3'h6:    f = '{1'b1, 1'b1, 1'b0, 1'b0};
            default: f = '{1'b1, 1'b1, 1'b1, 1'b0};
        endcase
        return f;
    endfunction

endpackage

// ==== async_tx_shifter.sv ====
// Purpose: Transmit serializer with start, parity and stop framing.
// Assumes: bitTick is a one-cycle pulse per bit time.
// Notes:   Format is read live on every bit.
`timescale 1ns/1ns
module async_tx_shifter
    import async_adapter_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       init,
    input  wire logic       bitTick,
    input  wire logic       holdFull,
    input  wire logic [7:0] holdData,
    input  wire word_fmt_t  fmt,
    output logic            txd,
    output logic            take
);

    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } tx_state_t;

    tx_state_t  state_reg;
    logic [7:0] shift_reg;
    logic [2:0] bitIdx_reg;
    logic       parity_reg;
    logic       stopIdx_reg;
    logic       frameEnd;

    // A stop count cut to one during the second stop bit ends the frame at once instead of never.
    assign frameEnd = (state_reg == TX_STOP) && (stopIdx_reg || !fmt.twoStop);
    assign take     = bitTick && holdFull && ((state_reg == TX_IDLE) || frameEnd);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= TX_IDLE;
        end else if (init) begin
            state_reg <= TX_IDLE;
        end else if (bitTick) begin
            case (state_reg)
                TX_IDLE:  state_reg <= holdFull ? TX_START : TX_IDLE;
                TX_START: state_reg <= TX_DATA;
                TX_DATA: begin
                    if (bitIdx_reg == (fmt.eightBits ? LAST_BIT_8 : LAST_BIT_7)) begin
                        state_reg <= fmt.parityOn ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR:   state_reg <= TX_STOP;
                TX_STOP: begin
                    if (frameEnd) begin
                        state_reg <= holdFull ? TX_START : TX_IDLE;
                    end
                end
                default:  state_reg <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_reg   <= 8'h00;
            bitIdx_reg  <= 3'h0;
            parity_reg  <= 1'b0;
            stopIdx_reg <= 1'b0;
        end else if (take) begin
            shift_reg   <= holdData;
            bitIdx_reg  <= 3'h0;
            parity_reg  <= 1'b0;
            stopIdx_reg <= 1'b0;
        end else if (bitTick && (state_reg == TX_DATA)) begin
            shift_reg  <= {1'b0, shift_reg[7:1]};
            bitIdx_reg <= bitIdx_reg + 3'h1;
            parity_reg <= parity_reg ^ shift_reg[0];
        end else if (bitTick && (state_reg == TX_STOP)) begin
            stopIdx_reg <= 1'b1;
        end
    end

    always_comb begin
        case (state_reg)
            TX_START: txd = 1'b0;
            TX_DATA:  txd = shift_reg[0];
            TX_PAR:   txd = parity_reg ^ fmt.parityOdd;
            default:  txd = 1'b1;
        endcase
    end

endmodule

// ==== async_rx_shifter.sv ====
// Purpose: Receive deserializer with parity and framing checks.
// Assumes: sampleTick falls at each bit middle, first one on the start bit.
// Notes:   Only the first stop bit is checked.
`timescale 1ns/1ns
module async_rx_shifter
    import async_adapter_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       init,
    input  wire logic       sampleTick,
    input  wire logic       rxd,
    input  wire word_fmt_t  fmt,
    output logic            done,
    output logic [7:0]      data,
    output logic            parityErr,
    output logic            frameErr
);

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_DATA = 4'h2,
        RX_PAR  = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

    rx_state_t  state_reg;
    logic [2:0] bitIdx_reg;
    logic       parity_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg  <= RX_IDLE;
            bitIdx_reg <= 3'h0;
            parity_reg <= 1'b0;
            data       <= 8'h00;
            parityErr  <= 1'b0;
            frameErr   <= 1'b0;
            done       <= 1'b0;
        end else if (init) begin
            state_reg <= RX_IDLE;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (sampleTick) begin
                case (state_reg)
                    RX_IDLE: begin
                        if (!rxd) begin
                            state_reg  <= RX_DATA;
                            bitIdx_reg <= 3'h0;
                            parity_reg <= 1'b0;
                            parityErr  <= 1'b0;
                            data       <= 8'h00;
                        end
                    end
                    RX_DATA: begin
                        data[bitIdx_reg] <= rxd;
                        parity_reg       <= parity_reg ^ rxd;
                        bitIdx_reg       <= bitIdx_reg + 3'h1;
                        if (bitIdx_reg == (fmt.eightBits ? LAST_BIT_8 : LAST_BIT_7)) begin
                            state_reg <= fmt.parityOn ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        parityErr <= (parity_reg ^ rxd) != fmt.parityOdd;
                        state_reg <= RX_STOP;
                    end
                    RX_STOP: begin
                        frameErr  <= !rxd;
                        done      <= 1'b1;
                        state_reg <= RX_IDLE;
                    end
                    default: state_reg <= RX_IDLE;
                endcase
            end
        end
    end

endmodule

// ==== serial_peer.sv ====
// Purpose: Far-side serial peer for the adapter core.
// Assumes: Bit clock runs free, sixteen system clocks a bit.
// Notes:   Echoes every transmitted frame back to the receiver.
`timescale 1ns/1ns
module serial_peer
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic txData,
    input  wire logic carrierLost,
    output logic      rxData,
    output logic      txClk,
    output logic      rxClk,
    output logic      carrierDetectN
);
    logic [3:0] divCnt;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) divCnt <= 4'h0;
        else divCnt <= divCnt + 4'h1;
    // Receive edges sit half a bit after transmit edges, so sampling lands mid-bit.
    assign txClk          = divCnt[3];
    assign rxClk          = ~divCnt[3];
    assign rxData         = txData;
    assign carrierDetectN = carrierLost;
endmodule

// ==== async_adapter_chk.sv ====
// Purpose: Port checker for the adapter core.
// Assumes: Control bytes take effect at the strobe fall.
// Notes:   Mirrors the control byte, so checks lag by a few cycles.
`timescale 1ns/1ns
module async_adapter_chk
    import async_adapter_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       enable,
    input wire logic       chipSelect,
    input wire logic       registerSelect,
    input wire logic       readNotWrite,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic       dataOe,
    input wire logic       txData,
    input wire logic       requestToSendN,
    input wire logic       clearToSendN,
    input wire logic       irqN
);
    logic [7:0] ctrlReg, wrByte;
    logic       enPrev, wrCtrl, freed;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) {ctrlReg, wrByte, enPrev, wrCtrl, freed} <= '0;
        else begin
            enPrev <= enable;
            if (enable) {wrByte, wrCtrl} <= {dataIn, chipSelect & ~registerSelect & ~readNotWrite};
            if (enPrev && !enable && wrCtrl) {ctrlReg, freed} <= {wrByte, freed | (&wrByte[1:0])};
        end
    AST_RTS_HIGH: assert property ((ctrlReg[6:5] == TXC_RTS_HIGH) [*3] |-> requestToSendN) else $error("rts low");
    AST_RTS_LOW: assert property ((ctrlReg[6:5] != TXC_RTS_HIGH) [*3] |-> !requestToSendN) else $error("rts high");
    AST_BREAK: assert property ((ctrlReg[6:5] == TXC_BREAK) [*3] |-> !txData) else $error("no break");
    AST_IRQ_OFF: assert property ((!ctrlReg[CTRL_RX_IRQ] && ctrlReg[6:5] != TXC_IRQ_ON) [*3] |-> irqN)
        else $error("irq while disabled");
    AST_OE_READ: assert property (dataOe |-> $past(enable) && $past(chipSelect) && $past(readNotWrite))
        else $error("bus driven off a read");
    AST_LATCH: assert property (!freed |-> txData && irqN && !requestToSendN) else $error("active before release");
    AST_MRESET: assert property ((ctrlReg[1:0] == DIV_RESET && ctrlReg[6:5] != TXC_BREAK) [*3] |-> txData && irqN)
        else $error("active in reset");
    AST_CTS: assert property (dataOe && !$past(registerSelect) |-> dataOut[3] == $past(clearToSendN)
        && !($past(clearToSendN) && dataOut[1])) else $error("cts status");
endmodule

// ==== async_adapter_core_test.sv ====
// Purpose: Self-checking bench for the adapter core.
// Assumes: Serial peer loops transmit back to receive.
// Notes:   Reads are checked in order from a queue.
`timescale 1ns/1ns
module async_adapter_core_test import async_adapter_pkg::*;;
    logic        clk, rstn, enable, chipSelect, registerSelect, readNotWrite, clearToSendN, carrierDetectN;
    logic        dataOe, txClk, rxClk, rxData, txData, requestToSendN, irqN, oePrev, carrierLost;
    logic [7:0]  dataIn, dataOut, d, q[$];
    logic [11:0] pinTbl = 12'h3D3;
    int          failures, compares, cyc, n, seed = 26865;
    async_adapter_core async_adapter_core_i (.*);
    serial_peer        serial_peer_i (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobe held two cycles so a read shows before the fall that clears flags.
    task automatic bus(input logic rs, input logic rw, input logic [7:0] v);
        @(posedge clk) #1;
        {enable, chipSelect, registerSelect, readNotWrite, dataIn} = {2'b11, rs, rw, v};
        repeat (2) @(posedge clk);
        #1 enable = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic rs, input logic [7:0] e);
        q.push_back(e);
        bus(rs, 1'b1, 8'h00);
    endtask
    task automatic wrap_up;
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (dataOe === 1'b1 && oePrev !== 1'b1 && q.size() > 0) cmp(dataOut, q.pop_front());
        oePrev = dataOe;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {rstn, enable, chipSelect, registerSelect, readNotWrite, clearToSendN, carrierLost, dataIn} = '0;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        rd(0, 8'h02);
        bus(0, 0, {6'h00, DIV_RESET});
        clearToSendN = 1'b1;
        repeat (2) @(posedge clk);
        rd(0, 8'h08);
        clearToSendN = 1'b0;
        for (int w = 0; w < 8; w++) begin
            d = 8'($random(seed));
            bus(0, 0, {1'b1, 2'b00, w[2:0], ((w == 7) ? DIV_BY_16 : DIV_BY_1)});
            bus(1, 0, d);
            n = 0;
            while (irqN !== 1'b0 && n < 4000) begin
                @(posedge clk) #1;
                n++;
            end
            #1 cmp({7'h00, irqN}, 8'h00);
            rd(0, 8'h83);
            rd(1, w[2] ? d : {1'b0, d[6:0]});
            rd(1, w[2] ? d : {1'b0, d[6:0]});
            rd(0, 8'h02);
        end
        carrierLost = 1'b1;
        rd(0, 8'h86);
        carrierLost = 1'b0;
        for (int c = 0; c < 4; c++) begin
            bus(0, 0, {1'b0, c[1:0], 5'h14});
            repeat (3) @(posedge clk);
            cmp({5'h00, requestToSendN, txData, irqN}, {5'h00, pinTbl[3 * c +: 3]});
        end
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
bind async_adapter_core async_adapter_chk async_adapter_chk_i (.*);
